// ---- design/backlight_pkg.sv ----
// package for the backlight control register bank: offsets, fields, resets, timing
// assumes a 125 MHz single clock and byte-wide registers
package backlight_pkg;
    localparam logic [7:0] dev_addr_write = 8'h58;
    localparam logic [7:0] dev_addr_read = 8'h59;
    localparam logic [6:0] dev_addr7 = 7'h2c;

    localparam logic [7:0] off_pwm_duty_level = 8'h00;
    localparam logic [7:0] off_device_control = 8'h01;
    localparam logic [7:0] off_fault_status = 8'h02;
    localparam logic [7:0] off_silicon_spin = 8'h03;
    localparam logic [7:0] off_dc_current_level = 8'h07;
    localparam logic [7:0] off_configuration = 8'h08;
    localparam logic [7:0] off_string_enable_health = 8'h09;
    localparam logic [7:0] off_phase_offset = 8'h0a;
    localparam logic [7:0] off_sync_divider_control = 8'h0b;

    localparam logic [7:0] rst_pwm_duty_level = 8'hff;
    localparam logic [7:0] rst_device_control = 8'h00;
    localparam logic [7:0] rst_dc_current_level = 8'hff;
    localparam logic [7:0] rst_configuration = 8'h1f;
    localparam logic [5:0] rst_string_enable = 6'h3f;
    localparam logic [7:0] rst_phase_offset = 8'h00;
    localparam logic [7:0] rst_sync_divider_control = 8'h10;

    // device control fields
    localparam int ctl_backlight_on = 0;
    localparam int ctl_brightness_source_select = 1;
    localparam int ctl_absolute_mode = 2;
    localparam logic [7:0] ctl_writable_mask = 8'h3f;
    // fault/status fields
    localparam int st_fault_summary = 0;
    localparam int st_thermal_fault_flag = 1;
    localparam int st_input_overcurrent_flag = 2;
    localparam int st_backlight_on_status = 3;
    localparam int st_one_string_down = 4;
    localparam int st_two_strings_down = 5;
    // configuration, phase offset and sync divider fields
    localparam int cfg_sync_loop_bypass = 7;
    localparam int cfg_direct_gating = 6;
    localparam int cfg_duty_to_analog = 5;
    localparam int cfg_boost_drive_hi = 4;
    localparam int cfg_boost_drive_lo = 3;
    localparam int cfg_switching_freq_select = 2;
    localparam int cfg_short_thresh_hi = 1;
    localparam int cfg_short_thresh_lo = 0;
    localparam int ph_uniform_phase_mode = 7;
    localparam int sync_frame_quarter_scaling = 7;

    // identity: upper five bits arbitrary, revision field arbitrary
    localparam logic [4:0] spin_upper_bits = 5'h15;
    localparam logic [2:0] spin_revision = 3'h0;

    // backlight turn-on delay: at most 4 ms, rounded down
    localparam int clk_freq_khz = 125000;
    localparam int turn_on_time_us = 4000;
    localparam int turn_on_cycles = turn_on_time_us * (clk_freq_khz / 1000);
    localparam int turn_on_cycles_sim = 16;
    localparam int settle_width = 20;
endpackage

// ---- design/i2c_byte_slave.sv ----
// i2c byte slave: address match, register pointer, single-byte write and read
// assumes scl and sda inputs synchronous to clk and sampled by it
`timescale 1ns/1ns
`default_nettype none
module i2c_byte_slave (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // register side
    output logic [7:0] reg_addr,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    output logic rd_sample,
    input wire logic [7:0] rd_data
);
    import backlight_pkg::*;

    typedef enum logic [2:0] {
        ph_idle, ph_dev, ph_ptr, ph_data, ph_read, ph_ack, ph_rack
    } phase_t;

    typedef struct packed {
        phase_t phase;
        phase_t after_ack;
        logic scl_q;
        logic sda_q;
        logic [2:0] bit_cnt;
        logic byte_done;
        logic [7:0] shifter;
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic have_data;
        logic reading;
        logic drive_low;
        logic [7:0] out_byte;
        logic wr_strobe;
        logic rd_sample;
    } slave_state_t;

    slave_state_t s_reg, s_next;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    always_comb begin
        scl_rise = scl_in && !s_reg.scl_q;
        scl_fall = !scl_in && s_reg.scl_q;
        start_cond = scl_in && s_reg.scl_q && s_reg.sda_q && !sda_in;
        stop_cond = scl_in && s_reg.scl_q && !s_reg.sda_q && sda_in;
        s_next = s_reg;
        s_next.scl_q = scl_in;
        s_next.sda_q = sda_in;
        s_next.wr_strobe = 1'b0;
        s_next.rd_sample = 1'b0;
        if (start_cond) begin
            if (s_reg.have_data) begin
                s_next.wr_strobe = 1'b1;
            end
            s_next.have_data = 1'b0;
            s_next.phase = ph_dev;
            s_next.bit_cnt = 3'd0;
            s_next.byte_done = 1'b0;
            s_next.drive_low = 1'b0;
        end else if (stop_cond) begin
            // write lands when the transaction completes with a stop or a repeated start
            s_next.wr_strobe = s_reg.have_data;
            s_next.have_data = 1'b0;
            s_next.phase = ph_idle;
            s_next.drive_low = 1'b0;
        end else begin
            unique case (s_reg.phase)
                ph_idle: begin
                end
                ph_dev, ph_ptr, ph_data: begin
                    if (scl_rise) begin
                        s_next.shifter = {s_reg.shifter[6:0], sda_in};
                        s_next.bit_cnt = s_reg.bit_cnt + 3'd1;
                        s_next.byte_done = s_reg.bit_cnt == 3'd7;
                    end
                    // the fall closing a start carries no bit, so bits count on rises
                    if (scl_fall) begin
                        if (s_reg.byte_done) begin
                            s_next.byte_done = 1'b0;
                            s_next.phase = ph_ack;
                            s_next.drive_low = 1'b1;
                            unique case (s_reg.phase)
                                ph_dev: begin
                                    // only 0x58 / 0x59 acknowledged
                                    if (s_reg.shifter[7:1] == dev_addr7) begin
                                        s_next.reading = s_reg.shifter[0];
                                        s_next.after_ack = s_reg.shifter[0] ? ph_read : ph_ptr;
                                    end else begin
                                        s_next.phase = ph_idle;
                                        s_next.drive_low = 1'b0;
                                    end
                                end
                                ph_ptr: begin
                                    s_next.ptr = s_reg.shifter;
                                    s_next.after_ack = ph_data;
                                end
                                default: begin
                                    // single byte only: further bytes are nacked
                                    s_next.wdata = s_reg.shifter;
                                    s_next.have_data = 1'b1;
                                    s_next.after_ack = ph_idle;
                                end
                            endcase
                        end
                    end
                end
                ph_ack: begin
                    if (scl_fall) begin
                        s_next.phase = s_reg.after_ack;
                        s_next.bit_cnt = 3'd0;
                        s_next.drive_low = 1'b0;
                        if (s_reg.after_ack == ph_read) begin
                            // sample register at start of data byte
                            s_next.rd_sample = 1'b1;
                            s_next.out_byte = rd_data;
                            s_next.drive_low = !rd_data[7];
                        end
                    end
                end
                ph_read: begin
                    if (scl_fall) begin
                        s_next.bit_cnt = s_reg.bit_cnt + 3'd1;
                        s_next.out_byte = {s_reg.out_byte[6:0], 1'b0};
                        s_next.drive_low = !s_reg.out_byte[6];
                        if (s_reg.bit_cnt == 3'd7) begin
                            s_next.phase = ph_rack;
                            s_next.drive_low = 1'b0;
                        end
                    end
                end
                ph_rack: begin
                    if (scl_fall) begin
                        s_next.phase = ph_idle;
                    end
                end
                default: s_next.phase = ph_idle;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '{phase: ph_idle, after_ack: ph_idle, scl_q: 1'b1, sda_q: 1'b1,
                       ptr: 8'h00, wdata: 8'h00, shifter: 8'h00, out_byte: 8'h00,
                       bit_cnt: 3'd0, default: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = s_reg.drive_low;
    assign reg_addr = s_reg.ptr;
    assign wr_data = s_reg.wdata;
    assign wr_strobe = s_reg.wr_strobe;
    assign rd_sample = s_reg.rd_sample;
endmodule
`default_nettype wire

// ---- design/backlight_control_registers.sv ----
// backlight control register bank: brightness, modes, string enables, faults
// assumes i2c pins and analog status inputs synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module backlight_control_registers #(
    parameter int turn_on_delay = backlight_pkg::turn_on_cycles
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // i2c pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // analog status
    input wire logic [5:0] string_fault,
    input wire logic input_overcurrent,
    input wire logic thermal_fault,
    // controls to the analog core
    output logic backlight_enable,
    output logic [5:0] string_drive_enable,
    output logic [7:0] applied_duty,
    output logic [7:0] dc_level,
    output logic use_external_pwm,
    output logic absolute_mode,
    output logic sync_loop_bypass,
    output logic direct_gating,
    output logic duty_to_analog,
    output logic [1:0] boost_drive_strength,
    output logic switching_freq_select,
    output logic [1:0] short_threshold,
    output logic uniform_phase_mode,
    output logic [6:0] phase_offset_step,
    output logic frame_quarter_scaling,
    output logic [6:0] sync_divider_value
);
    import backlight_pkg::*;

    typedef struct packed {
        logic [7:0] pwm_duty_level;
        logic [7:0] applied_duty;
        logic [5:0] device_control;
        logic [7:0] dc_current_level;
        logic [7:0] configuration;
        logic [5:0] output_lane_enable;
        logic [7:0] phase_offset;
        logic [7:0] sync_divider_control;
        logic fault_latched;
        logic backlight_active;
        logic [5:0] drive_enable;
        logic [settle_width-1:0] settle_cnt;
    } bank_state_t;

    bank_state_t b_reg, b_next;
    logic [7:0] reg_addr, wr_data, rd_data;
    logic wr_strobe, rd_sample;
    logic one_down, two_down, fault_now, ctl_write, bl_req;
    logic [5:0] healthy;

    function automatic logic [2:0] count_ones(input logic [5:0] v);
        logic [2:0] n;
        n = 3'd0;
        for (int i = 0; i < 6; i++) begin
            n = n + {2'b00, v[i]};
        end
        return n;
    endfunction

    i2c_byte_slave u_slave (
        .clk(clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .wr_strobe(wr_strobe),
        .rd_sample(rd_sample),
        .rd_data(rd_data)
    );

    always_comb begin
        // a string that is down is not healthy
        healthy = b_reg.output_lane_enable & ~string_fault
                  & {6{b_reg.backlight_active}};
        one_down = count_ones(string_fault & b_reg.output_lane_enable) >= 3'd1;
        two_down = count_ones(string_fault & b_reg.output_lane_enable) >= 3'd2;
        // status bit never feeds the summary; suppressed while off
        fault_now = b_reg.backlight_active
                    && (one_down || two_down || input_overcurrent || thermal_fault);
        ctl_write = wr_strobe && reg_addr == off_device_control;
        bl_req = b_reg.device_control[ctl_backlight_on];
    end

    always_comb begin
        unique case (reg_addr)
            off_pwm_duty_level: rd_data = b_reg.pwm_duty_level;
            off_device_control: rd_data = {2'b00, b_reg.device_control};
            off_fault_status: rd_data = {2'b00, two_down && b_reg.backlight_active,
                                         one_down && b_reg.backlight_active,
                                         b_reg.backlight_active, input_overcurrent,
                                         thermal_fault, b_reg.fault_latched};
            off_silicon_spin: rd_data = {spin_upper_bits, spin_revision};
            off_dc_current_level: rd_data = b_reg.dc_current_level;
            off_configuration: rd_data = b_reg.configuration;
            off_string_enable_health: rd_data = {2'b00, healthy};
            off_phase_offset: rd_data = b_reg.phase_offset;
            off_sync_divider_control: rd_data = b_reg.sync_divider_control;
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        b_next = b_reg;
        if (wr_strobe) begin
            unique case (reg_addr)
                off_pwm_duty_level: b_next.pwm_duty_level = wr_data;
                off_device_control: b_next.device_control = wr_data[5:0];
                off_dc_current_level: b_next.dc_current_level = wr_data;
                off_configuration: b_next.configuration = wr_data;
                off_string_enable_health: b_next.output_lane_enable = wr_data[5:0];
                off_phase_offset: b_next.phase_offset = wr_data;
                off_sync_divider_control: b_next.sync_divider_control = wr_data;
                default: begin
                end
            endcase
        end
        // duty reaches the core only in host mode
        if (!b_next.device_control[ctl_brightness_source_select]) begin
            b_next.applied_duty = b_next.pwm_duty_level;
        end
        // on/off sequencing
        if (!b_next.device_control[ctl_backlight_on]) begin
            b_next.backlight_active = 1'b0;
            b_next.settle_cnt = '0;
        end else if (!b_reg.backlight_active) begin
            if (b_reg.settle_cnt >= settle_width'(turn_on_delay - 1)) begin
                b_next.backlight_active = 1'b1;
            end else begin
                b_next.settle_cnt = b_reg.settle_cnt + 1'b1;
            end
        end
        // latched summary: toggle or written 0 clears, live fault sets again
        if (ctl_write && wr_data[ctl_backlight_on] != bl_req) begin
            b_next.fault_latched = 1'b0;
        end
        if (wr_strobe && reg_addr == off_fault_status && !wr_data[st_fault_summary]) begin
            b_next.fault_latched = 1'b0;
        end
        if (fault_now) begin
            b_next.fault_latched = 1'b1;
        end
        // registered so the drive pins carry no gate after the flops
        b_next.drive_enable = b_next.output_lane_enable & {6{b_next.backlight_active}};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            b_reg <= '{pwm_duty_level: rst_pwm_duty_level,
                       applied_duty: rst_pwm_duty_level,
                       device_control: rst_device_control[5:0],
                       dc_current_level: rst_dc_current_level,
                       configuration: rst_configuration,
                       output_lane_enable: rst_string_enable,
                       phase_offset: rst_phase_offset,
                       sync_divider_control: rst_sync_divider_control,
                       fault_latched: 1'b0, backlight_active: 1'b0, drive_enable: 6'h00,
                       settle_cnt: '0};
        end else begin
            b_reg <= b_next;
        end
    end

    // core controls straight from the register copy
    assign backlight_enable = b_reg.backlight_active;
    assign string_drive_enable = b_reg.drive_enable;
    assign applied_duty = b_reg.applied_duty;
    assign dc_level = b_reg.dc_current_level;
    assign use_external_pwm = b_reg.device_control[ctl_brightness_source_select];
    assign absolute_mode = b_reg.device_control[ctl_absolute_mode];
    assign sync_loop_bypass = b_reg.configuration[cfg_sync_loop_bypass];
    assign direct_gating = b_reg.configuration[cfg_direct_gating];
    assign duty_to_analog = b_reg.configuration[cfg_duty_to_analog];
    assign boost_drive_strength = b_reg.configuration[cfg_boost_drive_hi:cfg_boost_drive_lo];
    assign switching_freq_select = b_reg.configuration[cfg_switching_freq_select];
    assign short_threshold = b_reg.configuration[cfg_short_thresh_hi:cfg_short_thresh_lo];
    assign uniform_phase_mode = b_reg.phase_offset[ph_uniform_phase_mode];
    assign phase_offset_step = b_reg.phase_offset[6:0];
    assign frame_quarter_scaling = b_reg.sync_divider_control[sync_frame_quarter_scaling];
    assign sync_divider_value = b_reg.sync_divider_control[6:0];

    a_off_immediate: assert property (@(posedge clk) disable iff (rst)
        ctl_write && !wr_data[ctl_backlight_on] |=> !backlight_enable && string_drive_enable == 6'h00)
        else $error("backlight not off after off write");
    a_on_follows_req: assert property (@(posedge clk) disable iff (rst)
        backlight_enable |-> b_reg.device_control[ctl_backlight_on])
        else $error("backlight on without request");
    a_fault_sticky: assert property (@(posedge clk) disable iff (rst)
        b_reg.fault_latched && !wr_strobe |=> b_reg.fault_latched)
        else $error("fault summary dropped without clear");
    a_fault_sets: assert property (@(posedge clk) disable iff (rst)
        fault_now |=> b_reg.fault_latched)
        else $error("fault summary not set");
    a_duty_host_only: assert property (@(posedge clk) disable iff (rst)
        use_external_pwm && !$changed(use_external_pwm) |-> $stable(applied_duty))
        else $error("duty changed in external mode");
    a_ctl_top_zero: assert property (@(posedge clk) disable iff (rst)
        reg_addr == off_device_control |-> rd_data[7:6] == 2'b00)
        else $error("control bits 7..6 not zero");
    a_spin_readonly: assert property (@(posedge clk) disable iff (rst)
        reg_addr == off_silicon_spin |-> rd_data[2:0] == spin_revision)
        else $error("revision field changed");
    a_health_subset: assert property (@(posedge clk) disable iff (rst)
        (healthy & ~b_reg.output_lane_enable) == 6'h00)
        else $error("disabled string reads healthy");
endmodule
`default_nettype wire

// ---- testbench/i2c_host_model.sv ----
// i2c host model: single-byte register writes and reads
// assumes the bench resolves the open-drain data line
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
    // bus
    input wire logic clk,
    input wire logic sda_line,
    output logic scl = 1'b1,
    output logic sda = 1'b1
);
    import backlight_pkg::*;
    // pins move after a falling edge and hold four clocks
    task automatic pin(input logic c, input logic s);
        scl = c;
        sda = s;
        repeat (4) @(negedge clk);
    endtask
    // start, also repeated start from scl low
    task automatic st;
        pin(1'b0, 1'b1);
        pin(1'b1, 1'b1);
        pin(1'b1, 1'b0);
        pin(1'b0, 1'b0);
    endtask
    // one byte msb first, ninth bit released
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic [8:0] b;
        logic [8:0] r;
        b = {tx, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            pin(1'b0, b[i]);
            pin(1'b1, b[i]);
            r[i] = sda_line;
            pin(1'b0, b[i]);
        end
        rx = r[8:1];
        ack = !r[0];
    endtask
    // a read ends with a nack, so the device lets go before stop
    task automatic txn(input logic rd, input logic [7:0] dev, input logic [7:0] ad,
                       input logic [7:0] wd, output logic [7:0] rx, output logic ok);
        logic a1, a2, a3, a4;
        st;
        xfer(dev, rx, a1);
        xfer(ad, rx, a2);
        if (rd) st;
        xfer(rd ? dev_addr_read : wd, rx, a3);
        if (rd) xfer(8'hff, rx, a4);
        pin(1'b0, 1'b0);
        pin(1'b1, 1'b0);
        pin(1'b1, 1'b1);
        ok = a1 & a2 & a3;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// bench for the backlight register bank: i2c traffic, status inputs
// assumes the host model and the design share one clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import backlight_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] string_fault = 6'h00;
    logic input_overcurrent = 1'b0;
    logic thermal_fault = 1'b0;
    logic scl, host_sda, sda_out, sda_oe, backlight_enable, use_external_pwm, absolute_mode;
    logic sync_loop_bypass, direct_gating, duty_to_analog, switching_freq_select, ok;
    logic uniform_phase_mode, frame_quarter_scaling;
    logic [1:0] boost_drive_strength, short_threshold;
    logic [5:0] string_drive_enable, en;
    logic [6:0] phase_offset_step, sync_divider_value;
    logic [7:0] applied_duty, dc_level, rd, d, pw;
    logic [7:0] ap = 8'hff;
    int fails = 0;
    int compares = 0;
    int seed = 32'h8513c486;
    logic [7:0] ro [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h05};
    logic [7:0] re [10] = '{8'hff, 8'h00, 8'h00, {spin_upper_bits, spin_revision}, 8'hff,
                            8'h1f, 8'h00, 8'h00, 8'h10, 8'h00};
    // open drain: a released line floats high
    wire logic sda_line = sda_oe ? sda_out : host_sda;
    wire logic [7:0] cfg = {sync_loop_bypass, direct_gating, duty_to_analog,
                            boost_drive_strength, switching_freq_select, short_threshold};
    backlight_control_registers #(.turn_on_delay(turn_on_cycles_sim)) dut (
        .clk, .rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .string_fault,
        .input_overcurrent, .thermal_fault, .backlight_enable, .string_drive_enable,
        .applied_duty, .dc_level, .use_external_pwm, .absolute_mode, .sync_loop_bypass,
        .direct_gating, .duty_to_analog, .boost_drive_strength, .switching_freq_select,
        .short_threshold, .uniform_phase_mode, .phase_offset_step, .frame_quarter_scaling,
        .sync_divider_value);
    i2c_host_model host (.clk, .sda_line, .scl, .sda(host_sda));
    always #4 clk = ~clk;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.txn(1'b0, dev_addr_write, a, v, rd, ok);
        chk("write ack", 8'h01, {7'h0, ok});
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
        host.txn(1'b1, dev_addr_write, a, 8'h00, rd, ok);
        chk(nm, e, rd);
    endtask
    // status while lit: only enabled strings count as down
    function automatic logic [7:0] stat(input logic s);
        int n;
        n = $countones(en & string_fault);
        return {2'b00, n > 1, n > 0, 1'b1, input_overcurrent, thermal_fault, s};
    endfunction
    task automatic end_of_test;
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // about twice the expected run, well under the cycle budget
    initial begin
        #600000;
        fails++;
        end_of_test;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        foreach (ro[i]) rc("reset value", ro[i], re[i]);
        host.txn(1'b0, 8'h5a, 8'h07, 8'h00, rd, ok);
        chk("foreign address ack", 8'h00, {7'h0, ok});
        rc("dc_current_level", 8'h07, 8'hff);
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            wr(8'h01, d);
            rc("device_control", 8'h01, d & 8'h3f);
            chk("modes", {6'h0, d[2:1]}, {6'h0, absolute_mode, use_external_pwm});
            pw = 8'($random(seed));
            wr(8'h00, pw);
            if (d[1]) begin
                rc("pwm_duty_level", 8'h00, pw);
                chk("duty held", ap, applied_duty);
            end else begin
                ap = pw;
                chk("applied_duty", pw, applied_duty);
            end
            d = 8'($random(seed));
            wr(8'h07, d);
            chk("dc_level", d, dc_level);
            rc("dc_current_level", 8'h07, d);
            d = 8'($random(seed));
            wr(8'h08, d);
            rc("configuration", 8'h08, d);
            chk("config fields", d, cfg);
            d = 8'($random(seed));
            d[6:0] = d[6:0] % 7'd52;
            wr(8'h0a, d);
            chk("phase", d, {uniform_phase_mode, phase_offset_step});
            rc("phase_offset", 8'h0a, d);
            d = 8'($random(seed));
            wr(8'h0b, d);
            rc("sync_divider_control", 8'h0b, d);
            chk("sync", d, {frame_quarter_scaling, sync_divider_value});
        end
        wr(8'h01, 8'h00);
        en = 6'($random(seed)) | 6'h01;
        wr(8'h09, {2'b00, en});
        rc("strings while off", 8'h09, 8'h00);
        wr(8'h01, 8'h01);
        repeat (20) @(negedge clk);
        chk("backlight_enable", 8'h01, {7'h0, backlight_enable});
        chk("string_drive_enable", {2'b00, en}, {2'b00, string_drive_enable});
        rc("on status", 8'h02, 8'h08);
        string_fault = 6'($random(seed));
        input_overcurrent = 1'b1;
        rc("fault_status", 8'h02, stat(1'b1));
        rc("string_enable_health", 8'h09, {2'b00, en & ~string_fault});
        string_fault = 6'h00;
        input_overcurrent = 1'b0;
        thermal_fault = 1'b1;
        rc("thermal status", 8'h02, stat(1'b1));
        thermal_fault = 1'b0;
        rc("latched summary", 8'h02, 8'h09);
        wr(8'h02, 8'h00);
        rc("cleared summary", 8'h02, 8'h08);
        wr(8'h01, 8'h00);
        chk("backlight off", 8'h00, {7'h0, backlight_enable});
        rc("off status", 8'h02, 8'h00);
        rc("strings after off", 8'h09, 8'h00);
        end_of_test;
    end
endmodule
`default_nettype wire
